/* hw/pieb_pkg.sv */
// Package for the peripheral interrupt enable bank: register map, bit layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package pieb_pkg;

  localparam int unsigned PIEB_ADDR_W = 5;
  localparam int unsigned PIEB_NSRC   = 16;

  localparam logic [PIEB_ADDR_W-1:0] PIEB_OFF_EN_ONE  = 5'h00;
  localparam logic [PIEB_ADDR_W-1:0] PIEB_OFF_EN_TWO  = 5'h04;
  localparam logic [PIEB_ADDR_W-1:0] PIEB_OFF_CTRL    = 5'h08;
  localparam logic [PIEB_ADDR_W-1:0] PIEB_OFF_FLAGS   = 5'h0c;
  localparam logic [PIEB_ADDR_W-1:0] PIEB_OFF_STATUS  = 5'h10;
  localparam logic [PIEB_ADDR_W-1:0] PIEB_OFF_MASK    = 5'h14;

  // Control register bit positions
  localparam int unsigned PIEB_CTRL_GLOBAL = 7;
  localparam int unsigned PIEB_CTRL_PERIPH = 6;

  // First enable register bit positions
  localparam int unsigned PIEB_B1_TIMER_ONE_GATE = 7;
  localparam int unsigned PIEB_B1_CONVERTER      = 6;
  localparam int unsigned PIEB_B1_SERIAL_RX_ONE  = 5;
  localparam int unsigned PIEB_B1_SERIAL_TX_ONE  = 4;
  localparam int unsigned PIEB_B1_SYNC_PORT_ONE  = 3;
  localparam int unsigned PIEB_B1_CAPCOMP_ONE    = 2;
  localparam int unsigned PIEB_B1_TIMER_TWO      = 1;
  localparam int unsigned PIEB_B1_TIMER_ONE_OVF  = 0;

  // Second enable register bit positions
  localparam int unsigned PIEB_B2_OSC_FAIL       = 7;
  localparam int unsigned PIEB_B2_COMPARATOR_TWO = 6;
  localparam int unsigned PIEB_B2_COMPARATOR_ONE = 5;
  localparam int unsigned PIEB_B2_EEPROM_DONE    = 4;
  localparam int unsigned PIEB_B2_BUS_COLLISION  = 3;
  localparam int unsigned PIEB_B2_DISPLAY        = 2;
  localparam int unsigned PIEB_B2_COMPARATOR_THR = 1;
  localparam int unsigned PIEB_B2_CAPCOMP_TWO    = 0;

  localparam logic [7:0]  PIEB_RST_EN   = 8'h00;
  localparam logic [1:0]  PIEB_RST_CTRL = 2'h0;
  localparam logic [15:0] PIEB_RST_FLAG = 16'h0000;
  localparam logic [1:0]  PIEB_RST_STAT = 2'h0;

  // Status/mask bits of the block's own event register
  localparam int unsigned PIEB_EV_CORE_REQ = 0;
  localparam int unsigned PIEB_EV_NEW_FLAG = 1;

  localparam logic [1:0] PIEB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PIEB_RESP_SLVERR = 2'h2;

endpackage

/* hw/pieb_flag_bank.sv */
// Sticky request flags, one per source, set by source pulses and cleared by write-one.
// Assumes event pulses are on core_clk; set wins over a clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module pieb_flag_bank
  import pieb_pkg::*;
#(
  parameter int unsigned WIDTH = PIEB_NSRC
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clear_in,
  output logic      [WIDTH-1:0] flag_out,
  output logic                  any_new
);

  logic [WIDTH-1:0] flag_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          flag_r[g] <= 1'b0;
        end else if (set_in[g]) begin
          flag_r[g] <= 1'b1;
        end else if (clear_in[g]) begin
          flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flag_out = flag_r;
  assign any_new  = |(set_in & ~flag_r);

endmodule
`default_nettype wire

/* hw/pieb_axil_slave.sv */
// AXI4-Lite slave front end: accepts one write and one read, gives strobed register ports.
// Assumes a single master; answers one cycle after both write channels are taken.
`timescale 1ns/1ps
`default_nettype none
module pieb_axil_slave
  import pieb_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic [PIEB_ADDR_W-1:0] s_awaddr,
  input  wire logic                   s_awvalid,
  output logic                        s_awready,
  input  wire logic [31:0]            s_wdata,
  input  wire logic [3:0]             s_wstrb,
  input  wire logic                   s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire logic                   s_bready,
  input  wire logic [PIEB_ADDR_W-1:0] s_araddr,
  input  wire logic                   s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire logic                   s_rready,
  output logic                        wr_stb,
  output logic [PIEB_ADDR_W-1:0]      wr_addr,
  output logic [31:0]                 wr_data,
  output logic [3:0]                  wr_strb,
  input  wire logic                   wr_ok,
  output logic                        rd_stb,
  output logic [PIEB_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_ok
);

  logic                   aw_held_r;
  logic                   w_held_r;
  logic [PIEB_ADDR_W-1:0] aw_addr_r;
  logic [31:0]            w_data_r;
  logic [3:0]             w_strb_r;

  wire aw_take = s_awvalid & s_awready;
  wire w_take  = s_wvalid & s_wready;
  wire aw_have = aw_held_r | aw_take;
  wire w_have  = w_held_r | w_take;
  wire do_wr   = aw_have & w_have & ~s_bvalid;
  wire do_rd   = s_arvalid & s_arready;

  assign s_awready = ~aw_held_r & ~s_bvalid & rst_n;
  assign s_wready  = ~w_held_r & ~s_bvalid & rst_n;
  assign s_arready = ~s_rvalid & rst_n;

  assign wr_stb  = do_wr;
  assign wr_addr = aw_held_r ? aw_addr_r : s_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_wstrb;
  assign rd_stb  = do_rd;
  assign rd_addr = s_araddr;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= PIEB_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      aw_held_r <= aw_have & ~do_wr;
      w_held_r  <= w_have & ~do_wr;
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? PIEB_RESP_OKAY : PIEB_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= PIEB_RESP_OKAY;
    end else if (do_rd) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_data;
      s_rresp  <= rd_ok ? PIEB_RESP_OKAY : PIEB_RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* hw/pieb_top.sv */
// Peripheral interrupt enable bank: two enable registers, group and global gates, core request.
// Assumes source event pulses on core_clk and an AXI4-Lite master on the same clock.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Peripheral requests blocked unless the peripheral-group enable bit is set.
// - Both enable registers read/write, all bits reset to zero.
// - First register bit 7 gates timer-one gate acquisition interrupt.
// - First register bits 6,5,4,2 gate converter, receive, transmit, capture one.
// - First register bit 1 gates timer-two period match interrupt.
// - First register bit 0 gates timer-one overflow interrupt.
// - Second register bit 7 gates oscillator failure interrupt.
// - Second register bits 6,5,1,0 gate comparators two, one, three, capture two.
// - Second register bit 4 gates data EEPROM write completion interrupt.
// - Second register bit 3 gates synchronous port one bus collision interrupt.
// - Second register bit 2 gates display driver interrupt.
// - Request flags set on events regardless of any enable bit.
// - Global enable passes enabled requests when set, blocks all when clear.
module pieb_top
  import pieb_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic [PIEB_ADDR_W-1:0] s_awaddr,
  input  wire logic                   s_awvalid,
  output logic                        s_awready,
  input  wire logic [31:0]            s_wdata,
  input  wire logic [3:0]             s_wstrb,
  input  wire logic                   s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire logic                   s_bready,
  input  wire logic [PIEB_ADDR_W-1:0] s_araddr,
  input  wire logic                   s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire logic                   s_rready,
  input  wire logic                   timer_one_gate_evt,
  input  wire logic                   converter_done_evt,
  input  wire logic                   serial_rx_one_evt,
  input  wire logic                   serial_tx_one_evt,
  input  wire logic                   sync_port_one_evt,
  input  wire logic                   capcomp_one_evt,
  input  wire logic                   timer_two_match_evt,
  input  wire logic                   timer_one_overflow_evt,
  input  wire logic                   osc_fail_evt,
  input  wire logic                   comparator_two_evt,
  input  wire logic                   comparator_one_evt,
  input  wire logic                   eeprom_write_done_evt,
  input  wire logic                   bus_collision_one_evt,
  input  wire logic                   display_driver_evt,
  input  wire logic                   comparator_three_evt,
  input  wire logic                   capcomp_two_evt,
  output logic                        periph_irq_req,
  output logic                        irq
);

  logic [7:0] periph_irq_enable_one_r;
  logic [7:0] periph_irq_enable_two_r;
  logic       global_irq_enable_r;
  logic       periph_group_enable_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic       periph_irq_req_r;
  logic       irq_r;

  logic                   wr_stb;
  logic [PIEB_ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic                   rd_stb;
  logic [PIEB_ADDR_W-1:0] rd_addr;
  logic [31:0]            rd_data;
  logic [PIEB_NSRC-1:0]   flags;
  logic                   any_new;

  function automatic logic addr_known(input logic [PIEB_ADDR_W-1:0] a);
    return a == PIEB_OFF_EN_ONE || a == PIEB_OFF_EN_TWO || a == PIEB_OFF_CTRL ||
           a == PIEB_OFF_FLAGS || a == PIEB_OFF_STATUS || a == PIEB_OFF_MASK;
  endfunction

  pieb_axil_slave u_bus (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_ok     (addr_known(wr_addr)),
    .rd_stb    (rd_stb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_ok     (addr_known(rd_addr))
  );

  // Source order matches the enable layout: first register in the low byte.
  wire [7:0] evt_one = {timer_one_gate_evt, converter_done_evt, serial_rx_one_evt,
                        serial_tx_one_evt, sync_port_one_evt, capcomp_one_evt,
                        timer_two_match_evt, timer_one_overflow_evt};
  wire [7:0] evt_two = {osc_fail_evt, comparator_two_evt, comparator_one_evt,
                        eeprom_write_done_evt, bus_collision_one_evt, display_driver_evt,
                        comparator_three_evt, capcomp_two_evt};

  // Byte lane 0 carries register bits, lanes 0 and 1 for the flags; other lanes are ignored.
  wire lane0     = wr_stb & wr_strb[0];
  wire wr_en_one = lane0 & (wr_addr == PIEB_OFF_EN_ONE);
  wire wr_en_two = lane0 & (wr_addr == PIEB_OFF_EN_TWO);
  wire wr_ctrl   = lane0 & (wr_addr == PIEB_OFF_CTRL);
  wire wr_mask   = lane0 & (wr_addr == PIEB_OFF_MASK);
  wire wr_flags  = wr_stb & (wr_addr == PIEB_OFF_FLAGS);
  wire wr_status = lane0 & (wr_addr == PIEB_OFF_STATUS);

  wire [PIEB_NSRC-1:0] flag_clr = wr_flags ?
                                  {wr_strb[1] ? wr_data[15:8] : 8'h00,
                                   wr_strb[0] ? wr_data[7:0]  : 8'h00} : 16'h0000;

  pieb_flag_bank #(.WIDTH(PIEB_NSRC)) u_flags (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .set_in   ({evt_two, evt_one}),
    .clear_in (flag_clr),
    .flag_out (flags),
    .any_new  (any_new)
  );

  // Each source passes only when its own enable bit is one.
  wire [7:0] pass_one;
  wire [7:0] pass_two;
  assign pass_one[PIEB_B1_TIMER_ONE_GATE] = flags[PIEB_B1_TIMER_ONE_GATE] &
    periph_irq_enable_one_r[PIEB_B1_TIMER_ONE_GATE];
  assign pass_one[PIEB_B1_CONVERTER] = flags[PIEB_B1_CONVERTER] &
    periph_irq_enable_one_r[PIEB_B1_CONVERTER];
  assign pass_one[PIEB_B1_SERIAL_RX_ONE] = flags[PIEB_B1_SERIAL_RX_ONE] &
    periph_irq_enable_one_r[PIEB_B1_SERIAL_RX_ONE];
  assign pass_one[PIEB_B1_SERIAL_TX_ONE] = flags[PIEB_B1_SERIAL_TX_ONE] &
    periph_irq_enable_one_r[PIEB_B1_SERIAL_TX_ONE];
  assign pass_one[PIEB_B1_SYNC_PORT_ONE] = flags[PIEB_B1_SYNC_PORT_ONE] &
    periph_irq_enable_one_r[PIEB_B1_SYNC_PORT_ONE];
  assign pass_one[PIEB_B1_CAPCOMP_ONE] = flags[PIEB_B1_CAPCOMP_ONE] &
    periph_irq_enable_one_r[PIEB_B1_CAPCOMP_ONE];
  assign pass_one[PIEB_B1_TIMER_TWO] = flags[PIEB_B1_TIMER_TWO] &
    periph_irq_enable_one_r[PIEB_B1_TIMER_TWO];
  assign pass_one[PIEB_B1_TIMER_ONE_OVF] = flags[PIEB_B1_TIMER_ONE_OVF] &
    periph_irq_enable_one_r[PIEB_B1_TIMER_ONE_OVF];
  assign pass_two[PIEB_B2_OSC_FAIL] = flags[8+PIEB_B2_OSC_FAIL] &
    periph_irq_enable_two_r[PIEB_B2_OSC_FAIL];
  assign pass_two[PIEB_B2_COMPARATOR_TWO] = flags[8+PIEB_B2_COMPARATOR_TWO] &
    periph_irq_enable_two_r[PIEB_B2_COMPARATOR_TWO];
  assign pass_two[PIEB_B2_COMPARATOR_ONE] = flags[8+PIEB_B2_COMPARATOR_ONE] &
    periph_irq_enable_two_r[PIEB_B2_COMPARATOR_ONE];
  assign pass_two[PIEB_B2_EEPROM_DONE] = flags[8+PIEB_B2_EEPROM_DONE] &
    periph_irq_enable_two_r[PIEB_B2_EEPROM_DONE];
  assign pass_two[PIEB_B2_BUS_COLLISION] = flags[8+PIEB_B2_BUS_COLLISION] &
    periph_irq_enable_two_r[PIEB_B2_BUS_COLLISION];
  assign pass_two[PIEB_B2_DISPLAY] = flags[8+PIEB_B2_DISPLAY] &
    periph_irq_enable_two_r[PIEB_B2_DISPLAY];
  assign pass_two[PIEB_B2_COMPARATOR_THR] = flags[8+PIEB_B2_COMPARATOR_THR] &
    periph_irq_enable_two_r[PIEB_B2_COMPARATOR_THR];
  assign pass_two[PIEB_B2_CAPCOMP_TWO] = flags[8+PIEB_B2_CAPCOMP_TWO] &
    periph_irq_enable_two_r[PIEB_B2_CAPCOMP_TWO];

  wire any_enabled = |{pass_two, pass_one};
  wire group_gated = any_enabled & periph_group_enable_r;
  wire req_nxt     = group_gated & global_irq_enable_r;

  // Block events: core request rising, and any flag freshly set.
  wire [1:0] ev_in;
  assign ev_in[PIEB_EV_CORE_REQ] = req_nxt & ~periph_irq_req_r;
  assign ev_in[PIEB_EV_NEW_FLAG] = any_new;
  wire [1:0] status_clr = wr_status ? wr_data[1:0] : 2'h0;
  // A new event outweighs a write-one clear in the same cycle.
  wire [1:0] status_nxt = ev_in | (status_r & ~status_clr);
  wire       irq_nxt    = |(status_nxt & mask_r);

  assign rd_data = (rd_addr == PIEB_OFF_EN_ONE) ? {24'h000000, periph_irq_enable_one_r} :
                   (rd_addr == PIEB_OFF_EN_TWO) ? {24'h000000, periph_irq_enable_two_r} :
                   (rd_addr == PIEB_OFF_CTRL)   ? {24'h000000, global_irq_enable_r,
                                                   periph_group_enable_r, 6'h00} :
                   (rd_addr == PIEB_OFF_FLAGS)  ? {16'h0000, flags} :
                   (rd_addr == PIEB_OFF_STATUS) ? {30'h00000000, status_r} :
                   (rd_addr == PIEB_OFF_MASK)   ? {30'h00000000, mask_r} :
                   32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      periph_irq_enable_one_r <= PIEB_RST_EN;
      periph_irq_enable_two_r <= PIEB_RST_EN;
    end else begin
      if (wr_en_one) begin
        periph_irq_enable_one_r <= wr_data[7:0];
      end
      if (wr_en_two) begin
        periph_irq_enable_two_r <= wr_data[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {global_irq_enable_r, periph_group_enable_r} <= PIEB_RST_CTRL;
      mask_r                                       <= PIEB_RST_STAT;
    end else begin
      if (wr_ctrl) begin
        global_irq_enable_r   <= wr_data[PIEB_CTRL_GLOBAL];
        periph_group_enable_r <= wr_data[PIEB_CTRL_PERIPH];
      end
      if (wr_mask) begin
        mask_r <= wr_data[1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_r         <= PIEB_RST_STAT;
      periph_irq_req_r <= 1'b0;
      irq_r            <= 1'b0;
    end else begin
      status_r         <= status_nxt;
      periph_irq_req_r <= req_nxt;
      irq_r            <= irq_nxt;
    end
  end

  assign periph_irq_req = periph_irq_req_r;
  assign irq            = irq_r;

endmodule
`default_nettype wire

/* verif/pieb_src_model.sv */
// Source model: turns a one-cycle fire request into event pulses on the source lines.
// Assumes the bench raises fire_stb for one cycle only.
`timescale 1ns/1ps
`default_nettype none
module pieb_src_model (
  input  wire logic        core_clk,
  input  wire logic        fire_stb,
  input  wire logic [15:0] fire_vec,
  output logic      [15:0] evt
);
  // One-cycle pulses, so each firing counts as exactly one event
  always_ff @(posedge core_clk) begin
    evt <= fire_stb ? fire_vec : 16'h0000;
  end
endmodule
`default_nettype wire

/* verif/pieb_top_props.sv */
// Checker for the enable bank: bus answer timing, hold rules and request levels.
// Sees only the top ports; the bind follows the module.
`timescale 1ns/1ps
`default_nettype none
module pieb_top_props
  import pieb_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic                   s_awvalid,
  input wire logic                   s_awready,
  input wire logic                   s_wvalid,
  input wire logic                   s_wready,
  input wire logic [1:0]             s_bresp,
  input wire logic                   s_bvalid,
  input wire logic                   s_bready,
  input wire logic [PIEB_ADDR_W-1:0] s_araddr,
  input wire logic                   s_arvalid,
  input wire logic                   s_arready,
  input wire logic [31:0]            s_rdata,
  input wire logic [1:0]             s_rresp,
  input wire logic                   s_rvalid,
  input wire logic                   s_rready,
  input wire logic                   periph_irq_req,
  input wire logic                   irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_taken;
    s_arvalid && s_arready;
  endsequence
  rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
    !s_bvalid && !s_rvalid && !periph_irq_req && !irq) else $error("outputs not low after reset");
  wr_answer_a: assert property (wr_taken |=> s_bvalid) else $error("write answer late");
  rd_answer_a: assert property (rd_taken |=> s_rvalid) else $error("read answer late");
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  busy_block_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");
  ar_block_a: assert property (s_rvalid |-> !s_arready) else $error("read taken while busy");
  rd_unmap_a: assert property (rd_taken and s_araddr > PIEB_OFF_MASK |=>
    s_rresp == PIEB_RESP_SLVERR && s_rdata == 32'h0) else $error("unmapped read not refused");
  rd_width_a: assert property (rd_taken and s_araddr <= PIEB_OFF_EN_TWO |=>
    s_rresp == PIEB_RESP_OKAY && s_rdata[31:8] == 24'h0) else $error("enable read wrong");
  req_fall_a: assert property ($fell(periph_irq_req) |-> s_bvalid || $past(s_bvalid))
    else $error("request dropped without a write");
  irq_fall_a: assert property ($fell(irq) |-> s_bvalid || $past(s_bvalid))
    else $error("interrupt dropped without a write");
endmodule
bind pieb_top pieb_top_props u_props (.core_clk(core_clk), .rst_n(rst_n),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
  .s_rvalid(s_rvalid), .s_rready(s_rready), .periph_irq_req(periph_irq_req), .irq(irq));
`default_nettype wire

/* verif/peripheral_irq_enable_bank_test.sv */
// Self-checking bench for the enable bank against an integer reference model.
// Assumes the source model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_enable_bank_test;
  import pieb_pkg::*;
  logic                   core_clk, rst_n, s_awvalid, s_awready, s_wvalid, s_wready;
  logic                   s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic                   periph_irq_req, irq, fire_stb;
  logic [PIEB_ADDR_W-1:0] s_awaddr, s_araddr;
  logic [31:0]            s_wdata, s_rdata;
  logic [1:0]             s_bresp, s_rresp;
  logic [15:0]            fire_vec, evt;
  logic [3:0]             s_wstrb, ws;
  int                     num_errors, n_compared, seed, cycles, k, d;
  int                     m_en, m_ctl, m_flg, m_st, m_msk, m_req;

  pieb_top uut (.core_clk(core_clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .timer_one_gate_evt(evt[7]), .converter_done_evt(evt[6]),
    .serial_rx_one_evt(evt[5]), .serial_tx_one_evt(evt[4]), .sync_port_one_evt(evt[3]),
    .capcomp_one_evt(evt[2]), .timer_two_match_evt(evt[1]),
    .timer_one_overflow_evt(evt[0]), .osc_fail_evt(evt[15]), .comparator_two_evt(evt[14]),
    .comparator_one_evt(evt[13]), .eeprom_write_done_evt(evt[12]),
    .bus_collision_one_evt(evt[11]), .display_driver_evt(evt[10]),
    .comparator_three_evt(evt[9]), .capcomp_two_evt(evt[8]),
    .periph_irq_req(periph_irq_req), .irq(irq));
  pieb_src_model src (.core_clk(core_clk), .fire_stb(fire_stb), .fire_vec(fire_vec),
    .evt(evt));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // A hang anywhere ends the run as a mismatch
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      results();
    end
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic bit mapped(input logic [4:0] a);
    return a <= PIEB_OFF_MASK && a[1:0] == 2'b00;
  endfunction

  function automatic int mv(input logic [4:0] a);
    case (a)
      PIEB_OFF_EN_ONE: return m_en & 'hff;
      PIEB_OFF_EN_TWO: return m_en >> 8;
      PIEB_OFF_CTRL:   return m_ctl;
      PIEB_OFF_FLAGS:  return m_flg;
      PIEB_OFF_STATUS: return m_st;
      PIEB_OFF_MASK:   return m_msk;
      default:         return 0;
    endcase
  endfunction

  // Model: request is any flag ANDed with its enable, then both gates
  task automatic settle;
    int r;
    r = ((m_flg & m_en) != 0) && m_ctl[7] && m_ctl[6];
    if (r && !m_req) m_st = m_st | 1;
    m_req = r;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check("periph_irq_req", periph_irq_req, m_req);
    check("irq", irq, (m_st & m_msk) != 0);
  endtask

  task automatic wr(input logic [4:0] a, input int v);
    logic aw, w, b;
    logic [1:0] rsp;
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= v;
    s_wstrb <= ws;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge core_clk);
      aw = s_awready;
      w = s_wready;
      b = s_bvalid;
      rsp = s_bresp;
      @(posedge core_clk);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    check("bresp", rsp, mapped(a) ? PIEB_RESP_OKAY : PIEB_RESP_SLVERR);
    if (a == PIEB_OFF_FLAGS)
      m_flg = m_flg & ~(v & {ws[1] ? 8'hff : 8'h00, ws[0] ? 8'hff : 8'h00});
    else if (ws[0]) case (a)
      PIEB_OFF_EN_ONE: m_en = (m_en & 'hff00) | (v & 'hff);
      PIEB_OFF_EN_TWO: m_en = (m_en & 'hff) | ((v & 'hff) << 8);
      PIEB_OFF_CTRL:   m_ctl = v & 'hc0;
      PIEB_OFF_STATUS: m_st = m_st & ~v & 3;
      PIEB_OFF_MASK:   m_msk = v & 3;
      default: ;
    endcase
    settle();
  endtask

  task automatic rd(input logic [4:0] a);
    logic ar, v;
    logic [31:0] dat;
    logic [1:0] rsp;
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge core_clk);
      ar = s_arready;
      v = s_rvalid;
      dat = s_rdata;
      rsp = s_rresp;
      @(posedge core_clk);
      if (ar) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
    check("rdata", dat, mv(a));
    check("rresp", rsp, mapped(a) ? PIEB_RESP_OKAY : PIEB_RESP_SLVERR);
  endtask

  task automatic ev(input int v);
    @(posedge core_clk);
    fire_vec <= v;
    fire_stb <= 1'b1;
    @(posedge core_clk);
    fire_stb <= 1'b0;
    if ((v & ~m_flg & 'hffff) != 0) m_st = m_st | 2;
    m_flg = m_flg | (v & 'hffff);
    settle();
  endtask

  task automatic zero_model;
    {m_en, m_ctl, m_flg, m_st, m_msk, m_req} = '0;
  endtask

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fire_stb} = '0;
    {s_awaddr, s_araddr, s_wdata, fire_vec} = '0;
    s_wstrb = 4'hf;
    ws = 4'hf;
    {num_errors, n_compared, cycles} = '0;
    seed = 34807;
    rst_n = 1'b0;
    zero_model();
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 8; k++) rd(5'(k * 4));
    wr(5'h1c, 'hff);
    $display("reset values and map done");
    for (k = 0; k < 16; k++) begin
      wr(PIEB_OFF_CTRL, 0);
      wr(PIEB_OFF_EN_ONE, (1 << k) & 'hff);
      wr(PIEB_OFF_EN_TWO, (1 << k) >> 8);
      ev(1 << k);
      rd(PIEB_OFF_FLAGS);
      wr(PIEB_OFF_CTRL, 'hc0);
      wr(PIEB_OFF_CTRL, 'h80);
      wr(PIEB_OFF_CTRL, 'h40);
      wr(PIEB_OFF_FLAGS, 1 << k);
      ev(~(1 << k) & 'hffff);
      wr(PIEB_OFF_CTRL, 'hc0);
      wr(PIEB_OFF_FLAGS, 'hffff);
    end
    $display("per source gating done");
    for (k = 0; k < 150; k++) begin
      d = $random(seed);
      // Lane 0 off must leave registers alone; flags follow each lane
      ws = ($random(seed) & 1) ? 4'hf : 4'h2;
      case ($random(seed) & 7)
        0: wr(PIEB_OFF_EN_ONE, d);
        1: wr(PIEB_OFF_EN_TWO, d);
        2: wr(PIEB_OFF_CTRL, d);
        3: wr(PIEB_OFF_FLAGS, d);
        4: wr(PIEB_OFF_STATUS, d);
        5: wr(PIEB_OFF_MASK, d);
        6: ev(d & $random(seed));
        default: rd(5'((d & 7) * 4));
      endcase
    end
    $display("random traffic done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    zero_model();
    for (k = 0; k < 6; k++) rd(5'(k * 4));
    $display("second reset done");
    results();
  end
endmodule
`default_nettype wire
